/* File: host_data_fifo_consts.svh */
// Offsets, field positions, reset values and sizes of the host data buffer
`ifndef HOST_DATA_FIFO_CONSTS_SVH
`define HOST_DATA_FIFO_CONSTS_SVH

// ----------------------------------------------------------------------
// Capacity
// ----------------------------------------------------------------------
`define BUF_DEPTH        512
`define CAP_SMALL        255

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_FILL_COUNT   6'h00
`define IDX_DATA         6'h01
`define IDX_CTRL         6'h02
`define IDX_THRESH       6'h03
`define IDX_IRQ_STAT     6'h04
`define IDX_IRQ_EN       6'h05

// ----------------------------------------------------------------------
// Fields of buffer_ctrl_status
// ----------------------------------------------------------------------
`define CTRL_FLUSH       7
`define CTRL_NEAR_FULL   6
`define CTRL_NEAR_EMPTY  5
`define CTRL_SIZE        4
`define CTRL_OVERFLOW    3
`define CTRL_THR_HI      2
`define CTRL_COUNT_HI    0

// ----------------------------------------------------------------------
// Fields of irq_status_first and irq_enable_first
// ----------------------------------------------------------------------
`define IRQ_NEAR_EMPTY   0
`define IRQ_NEAR_FULL    1
`define IRQ_ERROR        2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define THRESH_RST       8'h08
`define IRQ_EN_RST       3'h0

`endif

/* File: host_data_fifo_pkg.sv */
// Types shared by the host data buffer
package host_data_fifo_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } eng_req_type;

  typedef struct packed {
    logic [5:0] idx;
    logic       write;
  } bus_req_type;

  typedef enum logic [1:0] {
    st_idle,
    st_write,
    st_rd_wait,
    st_rd_data
  } bus_state_type;

endpackage

/* File: buffer_mem.sv */
// Byte storage of the host data buffer, flip-flops with a direct read port
`timescale 1ns/100ps
`default_nettype none

module buffer_mem #(
  parameter int DW    = 8,
  parameter int DEPTH = 512,
  parameter int PW    = $clog2(DEPTH)
) (
  input  wire logic          sys_clk_i,
  input  wire logic          wr_en_i,
  input  wire logic [PW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [PW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_q [DEPTH];

  // Contents carry no reset: a read of the empty buffer still returns the stale byte at the read pointer
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_q[raddr_i];

endmodule

`default_nettype wire

/* File: host_data_fifo.sv */
// Host data buffer with fill level, alert flags, interrupts and AHB-Lite
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "host_data_fifo_consts.svh"

// How it works
// - One byte-wide buffer of 512 entries shared by host and engine.
// - Size-limit select caps capacity at 255 bytes; values fit one byte.
// - Full-size mode keeps count and threshold wider than one byte.
// - Engine reads and writes the buffer while a command runs.
// - Flush resets both pointers and clears the fill count.
// - Writes raise the count, reads lower it; upper bits sit in control.
// - Threshold is eight bits plus one high bit in the control register.
// - Near-full is set when free space is at most the threshold.
// - Near-empty is set when the count is at most the threshold.
// - A write into a full buffer raises overflow and the error flag.
// - Enabled near-empty rising edge drives the interrupt output.
// - Enabled near-full rising edge drives the interrupt output.

module host_data_fifo
  import host_data_fifo_pkg::*;
#(
  parameter int DEPTH = `BUF_DEPTH,
  parameter int AW    = 8
) (
  input  wire logic          sys_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          ce_i,
  input  wire logic          hsel_i,
  input  wire logic [AW-1:0] haddr_i,
  input  wire logic [1:0]    htrans_i,
  input  wire logic          hwrite_i,
  input  wire logic [2:0]    hsize_i,
  input  wire logic [31:0]   hwdata_i,
  input  wire logic          hready_i,
  output logic               hreadyout_o,
  output logic               hresp_o,
  output logic      [31:0]   hrdata_o,
  output logic               irq_o,
  input  wire logic          cmd_busy_i,
  input  wire eng_req_type   eng_req_i,
  output logic      [7:0]    eng_rdata_o,
  output logic      [9:0]    eng_count_o,
  output logic               eng_full_o,
  output logic               eng_empty_o
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  bus_state_type state_q;
  bus_req_type   req_q;
  logic [31:0]   hrdata_q;
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [CW-1:0] count_q;
  logic          size_q;
  logic          thr_hi_q;
  logic [7:0]    thr_q;
  logic          ovf_q;
  logic [2:0]    irq_stat_q;
  logic [2:0]    irq_en_q;
  logic          ne_prev_q;
  logic          nf_prev_q;
  logic [7:0]    eng_rdata_q;

  logic          accept;
  logic          host_wr;
  logic          host_push;
  logic          host_pop;
  logic          eng_push;
  logic          eng_pop;
  logic          push_req;
  logic          pop_req;
  logic          do_push;
  logic          do_pop;
  logic          flush;
  logic          full;
  logic          empty;
  logic          overflow_evt;
  logic [CW-1:0] cap;
  logic [CW-1:0] free;
  logic [CW-1:0] thr_eff;
  logic          near_full;
  logic          near_empty;
  logic [2:0]    irq_set;
  logic [2:0]    irq_clr;
  logic [7:0]    push_data;
  logic [7:0]    rd_byte;
  logic [31:0]   rd_value;
  logic [7:0]    ctrl_value;

  // ----------------------------------------------------------------------
  // AHB-Lite slave: writes take no wait, reads one wait state
  // ----------------------------------------------------------------------
  assign hreadyout_o = (state_q != st_rd_wait);
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_q;
  assign accept      = hreadyout_o && hsel_i && htrans_i[1] && hready_i;
  assign host_wr     = (state_q == st_write);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_q <= st_idle;
      req_q   <= '0;
    end else if (ce_i) begin
      if (state_q == st_rd_wait) begin
        state_q <= st_rd_data;
      end else if (accept) begin
        req_q   <= '{idx: haddr_i[7:2], write: hwrite_i};
        state_q <= hwrite_i ? st_write : st_rd_wait;
      end else begin
        state_q <= st_idle;
      end
    end
  end

  // Read value is formed in the wait state, after any earlier write landed
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (req_q.idx)
      `IDX_FILL_COUNT: rd_value[7:0] = count_q[7:0];
      `IDX_DATA:       rd_value[7:0] = rd_byte;
      `IDX_CTRL:       rd_value[7:0] = ctrl_value;
      `IDX_THRESH:     rd_value[7:0] = thr_q;
      `IDX_IRQ_STAT:   rd_value[2:0] = irq_stat_q;
      `IDX_IRQ_EN:     rd_value[2:0] = irq_en_q;
      default:         rd_value      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce_i && state_q == st_rd_wait) begin
      hrdata_q <= rd_value;
    end
  end

  always_comb begin
    ctrl_value                                 = 8'h00;
    ctrl_value[`CTRL_NEAR_FULL]                = near_full;
    ctrl_value[`CTRL_NEAR_EMPTY]               = near_empty;
    ctrl_value[`CTRL_SIZE]                     = size_q;
    ctrl_value[`CTRL_OVERFLOW]                 = ovf_q;
    ctrl_value[`CTRL_THR_HI]                   = thr_hi_q;
    ctrl_value[`CTRL_COUNT_HI +: 2]            = count_q[9:8];
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      size_q   <= 1'b0;
      thr_hi_q <= 1'b0;
      thr_q    <= `THRESH_RST;
      irq_en_q <= `IRQ_EN_RST;
    end else if (ce_i && host_wr) begin
      if (req_q.idx == `IDX_CTRL) begin
        size_q   <= hwdata_i[`CTRL_SIZE];
        thr_hi_q <= hwdata_i[`CTRL_THR_HI];
      end
      if (req_q.idx == `IDX_THRESH) begin
        thr_q <= hwdata_i[7:0];
      end
      if (req_q.idx == `IDX_IRQ_EN) begin
        irq_en_q <= hwdata_i[2:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Buffer access arbitration
  // ----------------------------------------------------------------------
  // Engine only touches the buffer during a command and wins a tie;
  // keeping clear of the command's bytes is the host's duty.
  assign eng_push  = cmd_busy_i && eng_req_i.wr;
  assign eng_pop   = cmd_busy_i && eng_req_i.rd;
  assign host_push = host_wr && req_q.idx == `IDX_DATA;
  assign host_pop  = state_q == st_rd_wait && req_q.idx == `IDX_DATA;
  assign flush     = host_wr && req_q.idx == `IDX_CTRL
                     && hwdata_i[`CTRL_FLUSH];
  assign push_req  = eng_push || host_push;
  assign pop_req   = eng_pop || host_pop;
  assign push_data = eng_push ? eng_req_i.wdata : hwdata_i[7:0];

  assign cap   = size_q ? CW'(`CAP_SMALL) : CW'(DEPTH);
  assign full  = count_q >= cap;
  assign empty = count_q == '0;

  assign do_push      = push_req && !full && !flush;
  assign do_pop       = pop_req && !empty && !flush;
  assign overflow_evt = push_req && full;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      count_q <= '0;
    end else if (ce_i) begin
      if (flush) begin
        wptr_q  <= '0;
        rptr_q  <= '0;
        count_q <= '0;
      end else begin
        wptr_q  <= wptr_q + PW'(do_push);
        rptr_q  <= rptr_q + PW'(do_pop);
        // A push and a pop in one cycle leave the count as it is
        count_q <= count_q + CW'(do_push) - CW'(do_pop);
      end
    end
  end

  buffer_mem #(
    .DW    (8),
    .DEPTH (DEPTH)
  ) u_mem (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (ce_i && do_push),
    .waddr_i   (wptr_q),
    .wdata_i   (push_data),
    .raddr_i   (rptr_q),
    .rdata_o   (rd_byte)
  );

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      eng_rdata_q <= 8'h00;
    end else if (ce_i && eng_pop) begin
      eng_rdata_q <= rd_byte;
    end
  end

  assign eng_rdata_o = eng_rdata_q;
  assign eng_count_o = 10'(count_q);
  assign eng_full_o  = full;
  assign eng_empty_o = empty;

  // ----------------------------------------------------------------------
  // Alert flags and interrupts
  // ----------------------------------------------------------------------
  // Nine-bit threshold only in full-size mode, else a single byte
  assign thr_eff    = size_q ? CW'(thr_q) : CW'({thr_hi_q, thr_q});
  assign free       = full ? '0 : cap - count_q;
  assign near_full  = free <= thr_eff;
  assign near_empty = count_q <= thr_eff;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ne_prev_q <= 1'b1;
      nf_prev_q <= 1'b0;
      ovf_q     <= 1'b0;
    end else if (ce_i) begin
      ne_prev_q <= near_empty;
      nf_prev_q <= near_full;
      // Overflow wins over a flush in the same cycle
      ovf_q     <= overflow_evt || (ovf_q && !flush);
    end
  end

  always_comb begin
    irq_set                  = 3'h0;
    irq_set[`IRQ_NEAR_EMPTY] = near_empty && !ne_prev_q;
    irq_set[`IRQ_NEAR_FULL]  = near_full && !nf_prev_q;
    irq_set[`IRQ_ERROR]      = overflow_evt;
    irq_clr = (host_wr && req_q.idx == `IDX_IRQ_STAT) ? hwdata_i[2:0] : 3'h0;
  end

  // A new event in the clearing cycle stays set
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_stat_q <= 3'h0;
    end else if (ce_i) begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  assign irq_o = |(irq_stat_q & irq_en_q);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_read_taken;
    ce_i && accept && !hwrite_i;
  endsequence
  sequence s_one_wait;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  sequence s_lone_push;
    ce_i && do_push && !do_pop && !flush;
  endsequence

  a_read_wait_state: assert property (s_read_taken |=> s_one_wait)
    else $error("read did not take exactly one wait state");
  a_push_counts: assert property (
    s_lone_push |=> count_q == $past(count_q) + 1'b1
                    && wptr_q == $past(wptr_q) + 1'b1)
    else $error("push did not raise count and write pointer");
  a_pop_counts: assert property (
    ce_i && do_pop && !do_push |=> count_q == $past(count_q) - 1'b1)
    else $error("pop did not lower count");
  a_flush_clears: assert property (
    ce_i && flush |=> count_q == '0 && wptr_q == '0 && rptr_q == '0)
    else $error("flush did not clear pointers and count");
  a_small_cap: assert property (
    size_q && count_q == CW'(`CAP_SMALL) && ce_i && host_push && !pop_req
    |=> count_q == CW'(`CAP_SMALL) && irq_stat_q[`IRQ_ERROR])
    else $error("small buffer accepted a byte past its capacity");
  a_empty_read: assert property (
    ce_i && empty && pop_req && !push_req && !flush
    |=> count_q == '0 && rptr_q == $past(rptr_q))
    else $error("read of empty buffer disturbed state");
  a_ne_irq_fires: assert property (
    ce_i && near_empty && !ne_prev_q && irq_en_q[`IRQ_NEAR_EMPTY]
    |=> irq_stat_q[`IRQ_NEAR_EMPTY]
        && (irq_o || !irq_en_q[`IRQ_NEAR_EMPTY]))
    else $error("enabled near-empty rise gave no interrupt");
  a_nf_irq_fires: assert property (
    ce_i && near_full && !nf_prev_q && irq_en_q[`IRQ_NEAR_FULL]
    |=> irq_stat_q[`IRQ_NEAR_FULL]
        && (irq_o || !irq_en_q[`IRQ_NEAR_FULL]))
    else $error("enabled near-full rise gave no interrupt");
  a_engine_gate: assert property (
    ce_i && !cmd_busy_i && !host_push && !host_pop && !flush
    |=> count_q == $past(count_q))
    else $error("buffer changed without a command or host access");

endmodule

`default_nettype wire

/* File: host_master.sv */
// Bus master model standing in for the host controller
`timescale 1ns/100ps
`default_nettype none

module host_master (
  input  wire logic        sys_clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic      [7:0]  haddr_o,
  output logic      [1:0]  htrans_o,
  output logic             hwrite_o,
  output logic      [2:0]  hsize_o,
  output logic      [31:0] hwdata_o,
  output logic             hang_o
);
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 8'h00;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h00000000;
    hang_o   = 1'b0;
  end

  // A slave that never answers would stall the run forever
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge sys_clk_i);
    while (hready_i !== 1'b1 && n < 50) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (hready_i !== 1'b1) begin
      hang_o <= 1'b1;
    end
  endtask

  // Data port is only touched while no command owns the buffer
  task automatic xfer(input logic wr, input logic [5:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel_o   <= 1'b1;
    haddr_o  <= {idx, 2'h0};
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    hsize_o  <= 3'h2;
    wait_ready();
    hsel_o   <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= wd;
    wait_ready();
    rd = hrdata_i;
  endtask
endmodule

`default_nettype wire

/* File: host_data_fifo_bench.sv */
// Self-checking bench for the host data buffer
`timescale 1ns/100ps
`default_nettype none
`include "host_data_fifo_consts.svh"

`define CHK(got, exp) \
  check_count++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("wrong value at %0t: got %h want %h", $time, got, exp); \
  end

module host_data_fifo_bench
  import host_data_fifo_pkg::*;
;
  logic        sys_clk;
  logic        sys_rst;
  logic        cmd_busy;
  eng_req_type eng_req;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic        hreadyout;
  logic        irq;
  logic        hang;
  logic [7:0]  eng_rdata;
  logic [9:0]  eng_count;
  logic        eng_full;
  logic        eng_empty;
  logic        hresp;
  logic        ce;
  int          n_errors;
  int          check_count;

  host_data_fifo host_data_fifo_i (
    .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .ce_i(ce),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .hrdata_o(hrdata), .irq_o(irq), .cmd_busy_i(cmd_busy),
    .eng_req_i(eng_req), .eng_rdata_o(eng_rdata),
    .eng_count_o(eng_count), .eng_full_o(eng_full),
    .eng_empty_o(eng_empty)
  );

  host_master host_master_i (
    .sys_clk_i(sys_clk), .hready_i(hreadyout), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata),
    .hang_o(hang)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge hang) begin
    n_errors++;
    print_verdict();
  end

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] dummy;
    host_master_i.xfer(1'b1, idx, {24'h000000, d}, dummy);
  endtask

  task automatic rc(input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] got;
    host_master_i.xfer(1'b0, idx, 32'h00000000, got);
    `CHK(got, {24'h000000, e})
  endtask

  // Engine bytes go in one per cycle, then one idle cycle lets count land
  task automatic eng(input logic busy, input logic w, input logic p,
                     input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      cmd_busy <= busy;
      eng_req  <= '{wr: w, rd: p, wdata: base + 8'(i)};
      @(posedge sys_clk);
    end
    cmd_busy <= 1'b0;
    eng_req  <= '0;
    @(posedge sys_clk);
  endtask

  initial begin
    sys_rst     = 1'b1;
    cmd_busy    = 1'b0;
    ce          = 1'b1;
    eng_req     = '0;
    n_errors    = 0;
    check_count = 0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    // ------------------------------------------------------------------
    // Reset values and host traffic
    // ------------------------------------------------------------------
    rc(`IDX_THRESH, `THRESH_RST);
    rc(`IDX_IRQ_EN, 8'h00);
    rc(`IDX_CTRL, 8'h20);
    rc(6'h3F, 8'h00);
    wr(`IDX_DATA, 8'hA1);
    wr(`IDX_DATA, 8'hB2);
    wr(`IDX_DATA, 8'hC3);
    rc(`IDX_FILL_COUNT, 8'h03);
    rc(`IDX_DATA, 8'hA1);
    rc(`IDX_FILL_COUNT, 8'h02);
    wr(`IDX_CTRL, 8'h80);
    rc(`IDX_FILL_COUNT, 8'h00);
    `CHK(eng_empty, 1'b1)
    `CHK(hresp, 1'b0)
    host_master_i.xfer(1'b0, `IDX_DATA, 32'h00000000, r);
    rc(`IDX_FILL_COUNT, 8'h00);
    // ------------------------------------------------------------------
    // Small capacity, near-full and overflow interrupts
    // ------------------------------------------------------------------
    wr(`IDX_CTRL, 8'h10);
    wr(`IDX_THRESH, 8'h02);
    wr(`IDX_IRQ_EN, 8'h07);
    wr(`IDX_IRQ_STAT, 8'h07);
    eng(1'b1, 1'b1, 1'b0, `CAP_SMALL - 2, 8'h00);
    rc(`IDX_IRQ_STAT, 8'h02);
    `CHK(irq, 1'b1)
    eng(1'b1, 1'b1, 1'b0, 2, 8'h00);
    `CHK(eng_full, 1'b1)
    wr(`IDX_DATA, 8'h77);
    `CHK(eng_count, 10'h0FF)
    rc(`IDX_CTRL, 8'h58);
    rc(`IDX_IRQ_STAT, 8'h06);
    wr(`IDX_IRQ_STAT, 8'h06);
    rc(`IDX_IRQ_STAT, 8'h00);
    `CHK(irq, 1'b0)
    // ------------------------------------------------------------------
    // Near-empty interrupt, masked then unmasked
    // ------------------------------------------------------------------
    wr(`IDX_IRQ_EN, 8'h00);
    wr(`IDX_CTRL, 8'h90);
    rc(`IDX_IRQ_STAT, 8'h01);
    `CHK(irq, 1'b0)
    rc(`IDX_CTRL, 8'h30);
    wr(`IDX_IRQ_EN, 8'h01);
    rc(`IDX_IRQ_EN, 8'h01);
    `CHK(irq, 1'b1)
    wr(`IDX_IRQ_STAT, 8'h01);
    rc(`IDX_IRQ_STAT, 8'h00);
    `CHK(irq, 1'b0)
    // ------------------------------------------------------------------
    // Full capacity with a nine-bit threshold of 256
    // ------------------------------------------------------------------
    wr(`IDX_CTRL, 8'h04);
    wr(`IDX_THRESH, 8'h00);
    eng(1'b1, 1'b1, 1'b0, 256, 8'h5A);
    rc(`IDX_CTRL, 8'h65);
    rc(`IDX_FILL_COUNT, 8'h00);
    eng(1'b1, 1'b1, 1'b0, 1, 8'h00);
    rc(`IDX_CTRL, 8'h45);
    rc(`IDX_FILL_COUNT, 8'h01);
    eng(1'b0, 1'b1, 1'b0, 1, 8'h00);
    `CHK(eng_count, 10'h101)
    eng(1'b1, 1'b0, 1'b1, 1, 8'h00);
    `CHK(eng_rdata, 8'h5A)
    `CHK(eng_count, 10'h100)
    `CHK(eng_empty, 1'b0)
    rc(`IDX_IRQ_STAT, 8'h03);
    `CHK(irq, 1'b1)
    // ------------------------------------------------------------------
    // Clock enable low freezes the buffer, then a reset in mid-run
    // ------------------------------------------------------------------
    ce <= 1'b0;
    eng(1'b1, 1'b1, 1'b0, 3, 8'h00);
    `CHK(eng_count, 10'h100)
    ce      <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    `CHK(eng_count, 10'h000)
    `CHK(eng_empty, 1'b1)
    rc(`IDX_THRESH, `THRESH_RST);
    rc(`IDX_CTRL, 8'h20);
    rc(`IDX_IRQ_STAT, 8'h00);
    print_verdict();
  end
endmodule

`default_nettype wire
